/* bench/mfs_engine_model.sv */
`timescale 1ns/1ps
module mfs_engine_model (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // block side
    input wire masterStart,
    input wire masterActive,
    input wire [2:0] losses,
    // bus outcome
    output reg arbLost,
    output reg addrSent,
    output reg frameDone
);
    reg [1:0] phase, tick;
    reg [2:0] lost;
    // lose arbitration losses times, then win and finish the frame
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {arbLost, addrSent, frameDone, phase, tick, lost} <= 10'h000;
        end else begin
            {arbLost, addrSent, frameDone} <= 3'h0;
            tick <= tick + 2'h1;
            if (masterStart) begin
                // enter the arbitration phase with a fresh tick and loss count
                {phase, tick, lost} <= 7'h20;
            end else if (!masterActive) begin
                phase <= 2'h0;
            end else if (phase != 2'h0 && tick == 2'h3) begin
                if (phase == 2'h2) {frameDone, phase} <= 3'h4;
                else if (lost < losses) {arbLost, lost} <= {1'b1, lost + 3'h1};
                else {addrSent, phase} <= 3'h6;
            end
        end
    end
endmodule // mfs_engine_model

/* bench/mfs_master_setup_chk.sv */
`timescale 1ns/1ps
module mfs_master_setup_chk (
    // watched ports
    input wire clk,
    input wire rst_b,
    input wire [3:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrite,
    input wire regRead,
    input wire [7:0] regRdData,
    input wire engineBusy,
    input wire arbLost,
    input wire masterStart,
    input wire frameNormal,
    input wire [3:0] frameControl,
    input wire dirMasterToSlave,
    input wire frameLock,
    input wire frameUnlock,
    input wire masterActive,
    input wire [2:0] retriesLeft
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire go = regWrite && regAddr == 4'h3 && regWrData[2:0] == 3'h2;
    wire lose = masterActive && arbLost;
    property p_start; go && !masterActive && !engineBusy |=> masterStart && masterActive; endproperty
    a_start: assert property (p_start) else $error("start missed");
    property p_busy; go && engineBusy |=> !masterStart; endproperty
    a_busy: assert property (p_busy) else $error("start while busy");
    property p_dir; masterStart |-> dirMasterToSlave == frameControl[3]; endproperty
    a_dir: assert property (p_dir) else $error("direction wrong");
    property p_lock;
        masterStart |-> frameLock == (frameControl inside {4'h3, 4'ha, 4'hb})
            && frameUnlock == (frameControl == 4'h6);
    endproperty
    a_lock: assert property (p_lock) else $error("lock decode wrong");
    property p_hold; !masterStart |-> $stable({frameNormal, frameControl}); endproperty
    a_hold: assert property (p_hold) else $error("frame setup moved");
    property p_dec; lose && retriesLeft != 3'h0 |=> retriesLeft == $past(retriesLeft) - 3'h1;
    endproperty
    a_dec: assert property (p_dec) else $error("retry count wrong");
    property p_end; lose && retriesLeft == 3'h0 |=> !masterActive [*2]; endproperty
    a_end: assert property (p_end) else $error("no stop on loss");
    property p_rd; !regRead |=> regRdData == 8'h00; endproperty
    a_rd: assert property (p_rd) else $error("read data outside slot");
    c_start: cover property (masterStart);
    c_end: cover property (lose && retriesLeft == 3'h0);
    c_busy: cover property (go && engineBusy);
endmodule // mfs_master_setup_chk
bind mfs_master_setup mfs_master_setup_chk u_chk (.*);

/* bench/tb_mfs_master_setup.sv */
`timescale 1ns/1ps
module tb_mfs_master_setup;
    reg clk, rst_b, regWrite, regRead, engineBusy;
    reg [3:0] regAddr;
    reg [7:0] regWrData, v, cfg;
    reg [2:0] losses;
    wire [7:0] regRdData;
    wire [3:0] frameControl;
    wire [2:0] retriesLeft;
    wire arbLost, addrSent, frameDone, masterStart, frameNormal, dirMasterToSlave;
    wire masterActive, irq, masterAbort;
    integer mismatches, comparisons, seed, i, n, s;
    localparam [39:0] CODES = 40'h03_4567_abef;
    mfs_master_setup u_dut (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .engineBusy(engineBusy), .arbLost(arbLost),
        .addrSent(addrSent), .frameDone(frameDone), .masterStart(masterStart),
        .masterAbort(masterAbort), .frameNormal(frameNormal), .frameControl(frameControl),
        .dirMasterToSlave(dirMasterToSlave), .frameLock(), .frameUnlock(),
        .masterActive(masterActive), .retriesLeft(retriesLeft), .irq(irq));
    mfs_engine_model u_eng (.clk(clk), .rst_b(rst_b), .masterStart(masterStart),
        .masterActive(masterActive), .losses(losses), .arbLost(arbLost),
        .addrSent(addrSent), .frameDone(frameDone));
    function [7:0] expSt(input [2:0] l, input [2:0] r);
        expSt = (l > r) ? 8'h03 : 8'h04;
    endfunction
    task chk(input [7:0] got, input [7:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge clk);
            {regAddr, regWrData, regWrite} <= {a, d, 1'b1};
            @(posedge clk);
            regWrite <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, output [7:0] d);
        begin
            @(posedge clk);
            {regAddr, regRead} <= {a, 1'b1};
            @(posedge clk);
            regRead <= 1'b0;
            #1 d = regRdData;
        end
    endtask
    task summarize;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, mismatches);
            if (mismatches == 0 && comparisons > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000 mismatches = mismatches + 1;
        summarize;
    end
    initial begin
        {rst_b, regWrite, regRead, engineBusy, regAddr, regWrData, losses} = 0;
        {mismatches, comparisons, seed} = {32'h0, 32'h0, 32'd53181};
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        rd(4'h0, v);
        chk(v, 8'h80);
        rd(4'hf, v);
        chk(v, 8'h00);
        for (i = 0; i < 10; i = i + 1) begin
            s = $random(seed);
            cfg = {s[7:4], CODES[39-4*i -: 4]};
            losses <= s[10:8];
            wr(4'h2, {5'h00, s[13:11]});
            wr(4'h0, cfg);
            rd(4'h0, v);
            chk(v, cfg);
            wr(4'h3, 8'h02);
            #1 chk({frameNormal, frameControl}, {cfg[7], cfg[3:0]});
            chk(dirMasterToSlave, cfg[3]);
            n = 0;
            while (masterActive && n < 200) begin
                @(posedge clk);
                #1 n = n + 1;
                if (addrSent) begin
                    @(posedge clk);
                    #1 chk(retriesLeft, cfg[6:4]);
                end
            end
            chk(n < 200, 1'b1);
            rd(4'h1, v);
            chk(v, expSt(losses, cfg[6:4]));
            chk(irq, |(expSt(losses, cfg[6:4]) & s[13:11]));
            rd(4'h4, v);
            chk(v[7:5], {1'b1, cfg[3], ~cfg[3]});
            wr(4'h1, 8'h07);
            rd(4'h1, v);
            chk(v, 8'h00);
            chk(irq, 1'b0);
        end
        // stop command while still arbitrating aborts the master frame
        cfg = 8'hff;
        losses <= 3'h7;
        wr(4'h0, cfg);
        wr(4'h3, 8'h02);
        wr(4'h3, 8'h03);
        #1 chk(masterAbort, 1'b1);
        chk(masterActive, 1'b0);
        engineBusy <= 1'b1;
        wr(4'h3, 8'h02);
        #1 chk(masterActive, 1'b0);
        rd(4'h0, v);
        chk(v, cfg);
        summarize;
    end
endmodule // tb_mfs_master_setup

/* verilog/mfs_code_decode.v */
`timescale 1ns/1ps
`include "mfs_defs.vh"

module mfs_code_decode (
    // control code
    input wire [3:0] code,
    // decoded meaning
    output reg isRead,
    output reg isWrite,
    output reg isLock,
    output reg isUnlock,
    output reg isValid
);
    always @* begin
        isRead = 1'b0;
        isWrite = 1'b0;
        isLock = 1'b0;
        isUnlock = 1'b0;
        case (code)
            `MFS_CC_RD_STATUS, `MFS_CC_RD_LADDR_LO, `MFS_CC_RD_LADDR_HI,
            `MFS_CC_RD_DATA: begin
                isRead = 1'b1; // [R6]
            end
            `MFS_CC_RD_LOCK: begin
                isRead = 1'b1; // [R6]
                isLock = 1'b1;
            end
            `MFS_CC_RD_UNLOCK: begin
                isRead = 1'b1; // [R6]
                isUnlock = 1'b1;
            end
            `MFS_CC_WR_CMD_LOCK, `MFS_CC_WR_DATA_LOCK: begin
                isWrite = 1'b1; // [R7]
                isLock = 1'b1;
            end
            `MFS_CC_WR_CMD, `MFS_CC_WR_DATA: begin
                isWrite = 1'b1; // [R7]
            end
            default: begin
                isRead = 1'b0;
            end
        endcase
        isValid = isRead | isWrite; // [R8]
    end
endmodule // mfs_code_decode

/* verilog/mfs_defs.vh */
`ifndef MFS_DEFS_VH
`define MFS_DEFS_VH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define MFS_ADDR_W 4
`define MFS_OFS_SETUP 4'h0
`define MFS_OFS_STATUS 4'h1
`define MFS_OFS_MASK 4'h2
`define MFS_OFS_CMD 4'h3
`define MFS_OFS_INFO 4'h4

// ----------------------------------------------------------------
// setup register fields
// ----------------------------------------------------------------
`define MFS_SETUP_RESET 8'h80
`define MFS_BIT_NORMAL 7
`define MFS_RETRY_HI 6
`define MFS_RETRY_LO 4
`define MFS_CTL_HI 3
`define MFS_CTL_LO 0
`define MFS_BIT_DIR 3

// ----------------------------------------------------------------
// status bits
// ----------------------------------------------------------------
`define MFS_ST_ARBLOST 0
`define MFS_ST_TXERR 1
`define MFS_ST_DONE 2
`define MFS_ST_W 3

// ----------------------------------------------------------------
// commands
// ----------------------------------------------------------------
`define MFS_CMD_MASTER_REQ 3'h2
`define MFS_CMD_STOP 3'h3

// ----------------------------------------------------------------
// control codes
// ----------------------------------------------------------------
`define MFS_CC_RD_STATUS 4'h0
`define MFS_CC_RD_LOCK 4'h3
`define MFS_CC_RD_LADDR_LO 4'h4
`define MFS_CC_RD_LADDR_HI 4'h5
`define MFS_CC_RD_UNLOCK 4'h6
`define MFS_CC_RD_DATA 4'h7
`define MFS_CC_WR_CMD_LOCK 4'hA
`define MFS_CC_WR_DATA_LOCK 4'hB
`define MFS_CC_WR_CMD 4'hE
`define MFS_CC_WR_DATA 4'hF

`endif

/* verilog/mfs_master_setup.v */
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "mfs_defs.vh"

// Behaviour
// [R1] bit 7: 0 broadcast, 1 normal frame
// [R2] 3-bit retry limit used directly as count
// [R3] retries exhausted: arbitration-lost and transmit-error set
// [R4] won retry reloads counter after address
// [R5] control code sent in every master frame
// [R6] read control codes 0,3,4,5,6,7
// [R7] write control codes A,B,E,F
// [R8] software never programs undefined control codes
// [R9] top control bit sets length/data direction
// [R10] register affects master operation only
// [R11] master request command 010 starts frame
// [R12] reset: normal addressing, other bits zero
module mfs_master_setup (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // register port
    input wire [3:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrite,
    input wire regRead,
    output reg [7:0] regRdData,
    // frame engine side
    input wire engineBusy,
    input wire arbLost,
    input wire addrSent,
    input wire frameDone,
    output reg masterStart,
    output reg masterAbort,
    output reg frameNormal,
    output reg [3:0] frameControl,
    output reg dirMasterToSlave,
    output reg frameLock,
    output reg frameUnlock,
    output reg masterActive,
    output reg [2:0] retriesLeft,
    // interrupt
    output reg irq
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    localparam S_IDLE = 2'b00;
    localparam S_ARB = 2'b01;
    localparam S_XFER = 2'b10;

    reg [7:0] setup;
    reg [`MFS_ST_W-1:0] status;
    reg [`MFS_ST_W-1:0] mask;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [2:0] next_retries;
    reg [`MFS_ST_W-1:0] stEvent;
    wire decRead;
    wire decWrite;
    wire decLock;
    wire decUnlock;
    wire decValid;

    wire setupWr = regWrite && (regAddr == `MFS_OFS_SETUP);
    wire cmdWr = regWrite && (regAddr == `MFS_OFS_CMD);
    wire startCmd = cmdWr && (regWrData[2:0] == `MFS_CMD_MASTER_REQ); // [R11]
    wire stopCmd = cmdWr && (regWrData[2:0] == `MFS_CMD_STOP);
    wire [2:0] retryLimit = setup[`MFS_RETRY_HI:`MFS_RETRY_LO];
    wire [3:0] ctlCode = setup[`MFS_CTL_HI:`MFS_CTL_LO];

    mfs_code_decode u_dec (
        .code(ctlCode),
        .isRead(decRead),
        .isWrite(decWrite),
        .isLock(decLock),
        .isUnlock(decUnlock),
        .isValid(decValid)
    );

    // ----------------------------------------------------------------
    // master sequencer
    // ----------------------------------------------------------------
    always @* begin
        next_state = state;
        next_retries = retriesLeft;
        stEvent = {`MFS_ST_W{1'b0}};
        case (state)
            S_IDLE: begin
                if (startCmd && !engineBusy) begin
                    next_state = S_ARB;
                    next_retries = retryLimit; // [R2]
                end
            end
            S_ARB: begin
                if (stopCmd) begin
                    next_state = S_IDLE;
                end else if (arbLost) begin
                    if (retriesLeft == 3'h0) begin
                        next_state = S_IDLE; // [R3]
                        stEvent[`MFS_ST_ARBLOST] = 1'b1;
                        stEvent[`MFS_ST_TXERR] = 1'b1;
                    end else begin
                        next_retries = retriesLeft - 3'h1; // [R2]
                    end
                end else if (addrSent) begin
                    next_state = S_XFER;
                    next_retries = retryLimit; // [R4]
                end
            end
            S_XFER: begin
                if (stopCmd) begin
                    next_state = S_IDLE;
                end else if (frameDone) begin
                    next_state = S_IDLE;
                    stEvent[`MFS_ST_DONE] = 1'b1;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            setup <= `MFS_SETUP_RESET; // [R12]
            status <= {`MFS_ST_W{1'b0}};
            mask <= {`MFS_ST_W{1'b0}};
            state <= S_IDLE;
            retriesLeft <= 3'h0;
            regRdData <= 8'h00;
            masterStart <= 1'b0;
            masterAbort <= 1'b0;
            frameNormal <= 1'b1;
            frameControl <= 4'h0;
            dirMasterToSlave <= 1'b0;
            frameLock <= 1'b0;
            frameUnlock <= 1'b0;
            masterActive <= 1'b0;
            irq <= 1'b0;
        end else begin
            if (setupWr) begin
                setup <= regWrData; // [R12]
            end
            if (regWrite && (regAddr == `MFS_OFS_MASK)) begin
                mask <= regWrData[`MFS_ST_W-1:0];
            end
            // set wins over write-one-to-clear
            if (regWrite && (regAddr == `MFS_OFS_STATUS)) begin
                status <= (status & ~regWrData[`MFS_ST_W-1:0]) | stEvent; // [R3]
            end else begin
                status <= status | stEvent; // [R3]
            end
            state <= next_state;
            retriesLeft <= next_retries;
            masterStart <= (state == S_IDLE) && (next_state == S_ARB);
            masterAbort <= (state != S_IDLE) && stopCmd;
            masterActive <= (next_state != S_IDLE);
            // settings latched per frame; slave paths never read these [R10]
            if ((state == S_IDLE) && (next_state == S_ARB)) begin
                frameNormal <= setup[`MFS_BIT_NORMAL]; // [R1]
                frameControl <= ctlCode; // [R5]
                dirMasterToSlave <= setup[`MFS_BIT_DIR]; // [R9]
                frameLock <= decLock;
                frameUnlock <= decUnlock;
            end
            irq <= |(next_irq_src(status, stEvent, mask));
            if (regRead) begin
                case (regAddr)
                    `MFS_OFS_SETUP: regRdData <= setup;
                    `MFS_OFS_STATUS: regRdData <= {{(8-`MFS_ST_W){1'b0}}, status};
                    `MFS_OFS_MASK: regRdData <= {{(8-`MFS_ST_W){1'b0}}, mask};
                    `MFS_OFS_INFO: regRdData <= {decValid, decWrite, decRead, 1'b0,
                        masterActive, retriesLeft};
                    default: regRdData <= 8'h00;
                endcase
            end else begin
                regRdData <= 8'h00;
            end
        end
    end

    // status as it stands after this edge, gated by the mask
    function [`MFS_ST_W-1:0] next_irq_src;
        input [`MFS_ST_W-1:0] st;
        input [`MFS_ST_W-1:0] ev;
        input [`MFS_ST_W-1:0] mk;
        reg [`MFS_ST_W-1:0] clr;
        begin
            clr = (regWrite && (regAddr == `MFS_OFS_STATUS)) ?
                regWrData[`MFS_ST_W-1:0] : {`MFS_ST_W{1'b0}};
            next_irq_src = ((st & ~clr) | ev) & mk;
        end
    endfunction
endmodule // mfs_master_setup
